// File: core/acc_pkg.sv
// Shared constants and types for the analog conversion control block.
package acc_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses on the bus)
  // ---------------------------------------------------------------
  localparam int unsigned ADR_W = 8;
  localparam logic [ADR_W-1:0] OFF_CTRL0 = 8'h00;
  localparam logic [ADR_W-1:0] OFF_CFG1 = 8'h04;
  localparam logic [ADR_W-1:0] OFF_RESULT = 8'h08;
  localparam logic [ADR_W-1:0] OFF_IRQ_STAT = 8'h0C;
  localparam logic [ADR_W-1:0] OFF_IRQ_MASK = 8'h10;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int unsigned GO_BIT = 2;
  localparam int unsigned IRQ_DONE_BIT = 6;
  localparam int unsigned IRQ_ABORT_BIT = 5;
  localparam logic [7:0] CTRL0_RST = 8'h00;
  localparam logic [7:0] CFG1_RST = 8'h00;
  localparam logic [7:0] RESULT_RST = 8'h00;
  localparam logic [7:0] IRQ_RST = 8'h00;

  // ---------------------------------------------------------------
  // Timing: clock cycles per bit-conversion period, per clock select
  // ---------------------------------------------------------------
  localparam logic [6:0] TAD_DIV_0 = 7'h02;
  localparam logic [6:0] TAD_DIV_1 = 7'h08;
  localparam logic [6:0] TAD_DIV_2 = 7'h20;
  localparam logic [6:0] TAD_DIV_RC = 7'h40;
  localparam logic [2:0] RESULT_MSB = 3'h7;
  localparam logic [1:0] RECOV_TADS = 2'h2;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0] clk_sel;
    logic rsv5;
    logic [1:0] chan;
    logic go;
    logic rsv1;
    logic on;
  } acc_ctrl_s;

  typedef struct packed {
    logic powered;
    logic sample;
    logic [1:0] chan;
    logic [7:0] dac;
    logic [7:0] cfg;
  } acc_ana_s;

  typedef enum logic [3:0] {
    ST_OFF = 4'b0001,
    ST_ACQ = 4'b0010,
    ST_CONV = 4'b0100,
    ST_RECOV = 4'b1000
  } acc_state_e;

endpackage : acc_pkg

// File: core/acc_tad_gen.sv
// Bit-conversion period tick generator for the conversion sequencer.
`timescale 1ns/1ns
module acc_tad_gen (
  input wire logic clk_i, // System clock.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic [1:0] clk_sel_i, // Conversion clock select.
  input wire logic restart_i, // Restart the period from zero.
  output logic tick_o // One-cycle pulse at the end of each period.
);
  import acc_pkg::*;

  logic [6:0] cnt_q;
  logic [6:0] cnt_d;
  logic [6:0] div;

  // Maps the clock select to the number of clock cycles per period.
  function automatic logic [6:0] div_for(input logic [1:0] sel);
    unique case (sel)
      2'h0: div_for = TAD_DIV_0;
      2'h1: div_for = TAD_DIV_1;
      2'h2: div_for = TAD_DIV_2;
      2'h3: div_for = TAD_DIV_RC;
    endcase
  endfunction : div_for

  // Counts clock cycles and wraps at the end of each period.
  always_comb
  begin
    div = div_for(clk_sel_i);
    tick_o = (cnt_q == div - 7'h01) && !restart_i;
    if (restart_i || tick_o)
    begin
      cnt_d = 7'h00;
    end
    else
    begin
      cnt_d = cnt_q + 7'h01;
    end
  end

  // Registers the period counter.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_q <= 7'h00;
    end
    else
    begin
      cnt_q <= cnt_d;
    end
  end

endmodule : acc_tad_gen

// File: core/acc_ctrl.sv
// Conversion control block: registers, sequencer and successive approximation.
//
// Behaviour
// [RULE_01] On completion load result, clear go/done bit 2, set completion flag bit 6.
// [RULE_02] Software sets pin direction of each analog channel to input first.
// [RULE_03] Software configures, powers on, waits acquisition time, then requests conversion.
// [RULE_04] Software clears flag, sets interrupt enables before starting for interrupt use.
// [RULE_05] Software polls go/done or takes interrupt, then reads result, clears flag.
// [RULE_06] Each result bit takes one bit-conversion period of the selected clock.
// [RULE_07] At least two bit-conversion periods pass after conversion before acquisition.
// [RULE_08] Software sets go/done in a write after the one powering on.
// [RULE_09] Clearing go/done mid-conversion aborts; result register stays unchanged.
// [RULE_10] After abort wait two periods, then acquire selected channel automatically.
// [RULE_11] Writing go/done as one while powered starts conversion; held until end. Code starts only from acquisition; a go write in recovery is dropped.
`timescale 1ns/1ns
module acc_ctrl (
  input wire logic clk_i, // System clock, 50 MHz.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic wb_cyc_i, // Bus cycle.
  input wire logic wb_stb_i, // Bus strobe.
  input wire logic wb_we_i, // Bus write enable.
  input wire logic [acc_pkg::ADR_W-1:0] wb_adr_i, // Bus byte address.
  input wire logic [3:0] wb_sel_i, // Bus byte lane selects.
  input wire logic [31:0] wb_dat_i, // Bus write data.
  output logic [31:0] wb_dat_o, // Bus read data.
  output logic wb_ack_o, // Bus acknowledge.
  input wire logic cmp_i, // Comparator: input at or above DAC code.
  output acc_pkg::acc_ana_s ana_o, // Controls toward the analog path.
  output logic irq_o // Level interrupt request.
);
  import acc_pkg::*;

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic ack_q;
  logic ack_d;
  logic [31:0] rdat_q;
  logic [31:0] rdat_d;
  acc_ctrl_s ctrl_q;
  acc_ctrl_s ctrl_d;
  logic [7:0] cfg_q;
  logic [7:0] cfg_d;
  logic [7:0] result_q;
  logic [7:0] result_d;
  logic [7:0] stat_q;
  logic [7:0] stat_d;
  logic [7:0] mask_q;
  logic [7:0] mask_d;
  acc_state_e state_q;
  acc_state_e state_d;
  logic [7:0] sar_q;
  logic [7:0] sar_d;
  logic [2:0] idx_q;
  logic [2:0] idx_d;
  logic [1:0] rec_q;
  logic [1:0] rec_d;
  acc_ana_s ana_d;
  logic wr_en;
  logic wr_ctrl;
  logic wr_cfg;
  logic wr_result;
  logic wr_stat;
  logic wr_mask;
  acc_ctrl_s wctrl;
  logic done_ev;
  logic abort_ev;
  logic tad_restart;
  logic tad_tick;
  logic [7:0] ev;

  // True when the word address matches a register offset.
  function automatic logic hit(input logic [ADR_W-1:0] adr, input logic [ADR_W-1:0] off);
    hit = (adr[ADR_W-1:2] == off[ADR_W-1:2]);
  endfunction : hit

  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------

  // Acknowledge one cycle after the request; writes land on the ack edge.
  always_comb
  begin
    ack_d = wb_cyc_i && wb_stb_i && !ack_q;
    wr_en = wb_cyc_i && wb_stb_i && wb_we_i && ack_q && wb_sel_i[0];
    wr_ctrl = wr_en && hit(wb_adr_i, OFF_CTRL0);
    wr_cfg = wr_en && hit(wb_adr_i, OFF_CFG1);
    wr_result = wr_en && hit(wb_adr_i, OFF_RESULT);
    wr_stat = wr_en && hit(wb_adr_i, OFF_IRQ_STAT);
    wr_mask = wr_en && hit(wb_adr_i, OFF_IRQ_MASK);
    wctrl = acc_ctrl_s'(wb_dat_i[7:0]);
    rdat_d = rdat_q;
    if (ack_d)
    begin
      rdat_d = 32'h0000_0000;
      if (hit(wb_adr_i, OFF_CTRL0))
      begin
        rdat_d[7:0] = ctrl_q;
      end
      else if (hit(wb_adr_i, OFF_CFG1))
      begin
        rdat_d[7:0] = cfg_q;
      end
      else if (hit(wb_adr_i, OFF_RESULT))
      begin
        rdat_d[7:0] = result_q;
      end
      else if (hit(wb_adr_i, OFF_IRQ_STAT))
      begin
        rdat_d[7:0] = stat_q;
      end
      else if (hit(wb_adr_i, OFF_IRQ_MASK))
      begin
        rdat_d[7:0] = mask_q;
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // ---------------------------------------------------------------
  // Bit-conversion period generator
  // ---------------------------------------------------------------

  // One tick per bit-conversion period of the selected conversion clock.
  acc_tad_gen u_tad (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clk_sel_i(ctrl_q.clk_sel),
    .restart_i(tad_restart),
    .tick_o(tad_tick)
  );

  // ---------------------------------------------------------------
  // Conversion sequencer
  // ---------------------------------------------------------------

  // Computes sequencer state, approximation register and control fields.
  always_comb
  begin
    state_d = state_q;
    ctrl_d = ctrl_q;
    cfg_d = cfg_q;
    sar_d = sar_q;
    idx_d = idx_q;
    rec_d = rec_q;
    result_d = result_q;
    done_ev = 1'b0;
    abort_ev = 1'b0;
    tad_restart = 1'b0;
    mask_d = wr_mask ? wb_dat_i[7:0] : mask_q;
    if (wr_cfg)
    begin
      cfg_d = wb_dat_i[7:0];
    end
    // Software may overwrite the result; a completion in the same cycle wins.
    if (wr_result)
    begin
      result_d = wb_dat_i[7:0];
    end
    // The go/done bit is owned by the sequencer; reserved bits stay zero, other fields follow software.
    if (wr_ctrl)
    begin
      ctrl_d = wctrl;
      ctrl_d.rsv5 = 1'b0;
      ctrl_d.rsv1 = 1'b0;
      ctrl_d.go = ctrl_q.go;
    end
    unique case (state_q)
      ST_OFF:
      begin
        // A go request in the write that powers the module on is ignored.
        ctrl_d.go = 1'b0;
        if (ctrl_q.on)
        begin
          state_d = ST_ACQ;
        end
      end
      ST_ACQ:
      begin
        if (!ctrl_q.on)
        begin
          state_d = ST_OFF;
        end
        else if (wr_ctrl && wctrl.go && wctrl.on)
        begin
          ctrl_d.go = 1'b1; // RULE_11
          state_d = ST_CONV; // RULE_11
          sar_d = 8'h80;
          idx_d = RESULT_MSB;
          tad_restart = 1'b1; // RULE_06
        end
      end
      ST_CONV:
      begin
        if (wr_ctrl && (!wctrl.go || !wctrl.on))
        begin
          // Abort: the partial code is dropped and the result kept.
          ctrl_d.go = 1'b0; // RULE_09
          abort_ev = 1'b1; // RULE_09
          state_d = ST_RECOV; // RULE_10
          rec_d = 2'h0;
          tad_restart = 1'b1; // RULE_10
        end
        else if (tad_tick)
        begin
          // One result bit is resolved per period, MSB first.
          sar_d[idx_q] = cmp_i; // RULE_06
          if (idx_q == 3'h0)
          begin
            result_d = sar_d; // RULE_01
            ctrl_d.go = 1'b0; // RULE_01
            done_ev = 1'b1; // RULE_01
            state_d = ST_RECOV; // RULE_07
            rec_d = 2'h0;
          end
          else
          begin
            sar_d[idx_q - 3'h1] = 1'b1;
            idx_d = idx_q - 3'h1;
          end
        end
      end
      ST_RECOV:
      begin
        // Hold off acquisition for two whole periods, then resume it if powered on, else go to off.
        if (tad_tick)
        begin
          if (rec_q == RECOV_TADS - 2'h1) // RULE_07
          begin
            state_d = ctrl_q.on ? ST_ACQ : ST_OFF; // RULE_10
          end
          else
          begin
            rec_d = rec_q + 2'h1;
          end
        end
      end
      default:
      begin
        state_d = ST_OFF;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Interrupt status
  // ---------------------------------------------------------------

  // Sticky event bits; hardware set wins over a write-one clear.
  always_comb
  begin
    ev = 8'h00;
    ev[IRQ_DONE_BIT] = done_ev; // RULE_01
    ev[IRQ_ABORT_BIT] = abort_ev;
  end

  for (genvar i = 0; i < 8; i++)
  begin : g_stat
    assign stat_d[i] = ev[i] || (stat_q[i] && !(wr_stat && wb_dat_i[i]));
  end

  assign irq_o = |(stat_q & mask_q);

  // ---------------------------------------------------------------
  // Analog path controls
  // ---------------------------------------------------------------

  // Sampling switch closes only while acquiring; DAC shows the trial code.
  always_comb
  begin
    ana_d.powered = ctrl_d.on;
    ana_d.sample = (state_d == ST_ACQ); // RULE_10
    ana_d.chan = ctrl_d.chan;
    ana_d.dac = sar_d;
    ana_d.cfg = cfg_d;
  end

  // ---------------------------------------------------------------
  // State registers
  // ---------------------------------------------------------------

  // Registers all state of the block.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
      ctrl_q <= acc_ctrl_s'(CTRL0_RST);
      cfg_q <= CFG1_RST;
      result_q <= RESULT_RST;
      stat_q <= IRQ_RST;
      mask_q <= IRQ_RST;
      state_q <= ST_OFF;
      sar_q <= 8'h00;
      idx_q <= 3'h0;
      rec_q <= 2'h0;
      ana_o <= '0;
    end
    else
    begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      ctrl_q <= ctrl_d;
      cfg_q <= cfg_d;
      result_q <= result_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      state_q <= state_d;
      sar_q <= sar_d;
      idx_q <= idx_d;
      rec_q <= rec_d;
      ana_o <= ana_d;
    end
  end

endmodule : acc_ctrl

// File: testbench/acc_ctrl_properties.sv
// Concurrent checks on the ports of the conversion control block.
`timescale 1ns/1ns
module acc_ctrl_props (
  input wire logic clk_i, // Clock.
  input wire logic rst_i, // Reset.
  input wire logic wb_cyc_i, // Bus cycle.
  input wire logic wb_stb_i, // Bus strobe.
  input wire logic wb_we_i, // Bus write.
  input wire logic [acc_pkg::ADR_W-1:0] wb_adr_i, // Bus address.
  input wire logic [3:0] wb_sel_i, // Byte selects.
  input wire logic [31:0] wb_dat_i, // Write data.
  input wire logic [31:0] wb_dat_o, // Read data.
  input wire logic wb_ack_o, // Acknowledge.
  input wire logic cmp_i, // Comparator.
  input wire acc_pkg::acc_ana_s ana_o, // Analog controls.
  input wire logic irq_o // Interrupt.
);
  import acc_pkg::*;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // -----------------------------------------------------------
  // Helper decode
  // -----------------------------------------------------------
  logic req;
  logic ctl_wr;
  // A fresh request and a committing control write.
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign ctl_wr = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i[7:2] == OFF_CTRL0[7:2];
  sequence s_start;
    ctl_wr && wb_dat_i[GO_BIT] && wb_dat_i[0] && ana_o.sample;
  endsequence
  sequence s_abort;
    ctl_wr && !wb_dat_i[GO_BIT] && wb_dat_i[0] && ana_o.powered && !ana_o.sample;
  endsequence
  sequence s_recover;
    !ana_o.sample [*4] ##[1:140] ana_o.sample;
  endsequence
  // -----------------------------------------------------------
  // Properties
  // -----------------------------------------------------------
  property p_ack;
    req |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  property p_unmapped;
    wb_ack_o && !wb_we_i && wb_adr_i[7:2] > 6'h04 |-> wb_dat_o == 32'h0;
  endproperty
  property p_power;
    ctl_wr |=> ana_o.powered == $past(wb_dat_i[0]);
  endproperty
  property p_start;
    s_start |=> !ana_o.sample && ana_o.dac == 8'h80;
  endproperty
  property p_abort;
    s_abort |=> s_recover;
  endproperty
  property p_gap;
    $rose(ana_o.sample) |-> !$past(ana_o.sample, 2) && !$past(ana_o.sample, 4);
  endproperty
  property p_step;
    $changed(ana_o.dac) && !ana_o.sample |=> $stable(ana_o.dac);
  endproperty
  a_ack: assert property (p_ack) else $error("ack not a single cycle after request");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_power: assert property (p_power) else $error("power state does not follow write");
  a_start: assert property (p_start) else $error("conversion did not start");
  a_abort: assert property (p_abort) else $error("abort recovery wrong");
  a_gap: assert property (p_gap) else $error("acquisition resumed too early");
  a_step: assert property (p_step) else $error("trial code moved too fast");
endmodule : acc_ctrl_props

bind acc_ctrl acc_ctrl_props i_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cmp_i(cmp_i),
  .ana_o(ana_o), .irq_o(irq_o));

// File: testbench/acc_ana_model.sv
// Behavioural sample-and-hold and comparator of the analog path.
`timescale 1ns/1ns
module acc_ana_model (
  input wire logic clk_i, // Clock.
  input wire acc_pkg::acc_ana_s ana_i, // Controls from the block.
  input wire logic [3:0][7:0] vin_i, // Input level per channel.
  output logic cmp_o // Comparator result.
);
  import acc_pkg::*;
  logic [7:0] hold_q = 8'h00;
  logic tog_q = 1'b0;
  // Track the selected channel while the switch is closed.
  always_ff @(posedge clk_i)
  begin
    if (ana_i.sample) hold_q <= vin_i[ana_i.chan];
    tog_q <= !tog_q;
  end
  // Compare the held level; an unpowered output wanders every cycle.
  assign cmp_o = ana_i.powered ? (hold_q >= ana_i.dac) : tog_q;
endmodule : acc_ana_model

// File: testbench/acc_ctrl_tb_top.sv
// Self-checking bench for the conversion control block.
`timescale 1ns/1ns
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module acc_ctrl_tb_top;
  import acc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [31:0] dat = 32'h0;
  logic [31:0] rd, wb_dat_o;
  logic wb_ack_o, cmp, irq_o;
  acc_ana_s ana;
  logic [3:0][7:0] vin = {8'hC3, 8'h5A, 8'h81, 8'h2E};
  logic [6:0] dv [4] = '{TAD_DIV_0, TAD_DIV_1, TAD_DIV_2, TAD_DIV_RC};
  int errors = 0, n_checks = 0, n;
  // Free-running 50 MHz clock.
  initial
  begin
    forever #10 clk_i = ~clk_i;
  end
  acc_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .cmp_i(cmp), .ana_o(ana), .irq_o(irq_o));
  acc_ana_model i_ana (.clk_i(clk_i), .ana_i(ana), .vin_i(vin), .cmp_o(cmp));
  // Print the counts and the verdict, then stop.
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
    begin
      $display("ALL TESTS PASSED");
    end
    else
    begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out
  // One classic bus cycle; holds until ack, then idles a cycle.
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (wb_ack_o !== 1'b1 && k < 20);
    rd = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
    if (k >= 20)
    begin
      errors++;
      close_out();
    end
  endtask : wb
  // Count cycles until sample (0) or irq (1) is seen high, bounded.
  task automatic wait_for(input bit which, input int lim);
    n = 1;
    while ((which ? irq_o : ana.sample) !== 1'b1 && n < lim)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= lim)
    begin
      errors++;
      close_out();
    end
  endtask : wait_for
  // Control byte from clock select, channel and go.
  function automatic logic [7:0] cw(input int s, input int c, input bit g);
    return {s[1:0], 1'b0, c[1:0], g, 2'b01};
  endfunction : cw
  // Main sequence.
  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int a = 0; a < 6; a++)
    begin
      wb(1'b0, 8'(a * 4), 8'h00);
      `CHK(rd, 32'h0)
    end
    // Config write lands in the register and on the analog controls; sel[0] low is ignored.
    wb(1'b1, OFF_CFG1, 8'hA5);
    sel <= 4'hE;
    wb(1'b1, OFF_CFG1, 8'h3C);
    sel <= 4'hF;
    wb(1'b0, OFF_CFG1, 8'h00);
    `CHK(rd[7:0], 8'hA5)
    `CHK(ana.cfg, 8'hA5)
    wb(1'b1, OFF_CTRL0, cw(0, 1, 1));
    wb(1'b0, OFF_CTRL0, 8'h00);
    `CHK(rd[7:0], cw(0, 1, 0))
    wb(1'b1, OFF_IRQ_MASK, 8'h40);
    $display("test reset done");
    for (int s = 0; s < 4; s++)
    begin
      wait_for(1'b0, 200);
      wb(1'b1, OFF_CTRL0, cw(s, s, 0));
      repeat (8) @(posedge clk_i);
      wb(1'b1, OFF_CTRL0, cw(s, s, 1));
      wb(1'b0, OFF_CTRL0, 8'h00);
      `CHK(rd[GO_BIT], 1'b1)
      wait_for(1'b1, 1000);
      `CHK(n, 8 * int'(dv[s]) - 2)
      wb(1'b0, OFF_CTRL0, 8'h00);
      `CHK(rd[7:0], cw(s, s, 0))
      wb(1'b0, OFF_RESULT, 8'h00);
      `CHK(rd[7:0], vin[s])
      wb(1'b0, OFF_IRQ_STAT, 8'h00);
      `CHK(rd[7:0], 8'h40)
      wb(1'b1, OFF_IRQ_STAT, 8'h40);
      `CHK(irq_o, 1'b0)
    end
    $display("test convert done");
    wait_for(1'b0, 200);
    wb(1'b1, OFF_CTRL0, cw(2, 1, 0));
    wb(1'b1, OFF_RESULT, 8'h77);
    repeat (8) @(posedge clk_i);
    wb(1'b1, OFF_CTRL0, cw(2, 1, 1));
    repeat (40) @(posedge clk_i);
    wb(1'b1, OFF_CTRL0, cw(2, 1, 0));
    wait_for(1'b0, 200);
    `CHK(n, 2 * int'(dv[2]) + 1)
    wb(1'b0, OFF_RESULT, 8'h00);
    `CHK(rd[7:0], 8'h77)
    wb(1'b0, OFF_IRQ_STAT, 8'h00);
    `CHK(rd[7:0], 8'h20)
    `CHK(irq_o, 1'b0)
    wb(1'b1, OFF_IRQ_MASK, 8'h20);
    `CHK(irq_o, 1'b1)
    wb(1'b1, OFF_IRQ_STAT, 8'h20);
    `CHK(irq_o, 1'b0)
    $display("test abort done");
    close_out();
  end
endmodule : acc_ctrl_tb_top
